//--- bench/crmi_arbiter.sv
// Purpose: bus arbiter model answering the interrupt request
// Assumes: grant follows the request after a chosen delay
// Notes: grant drops once the vector is taken or the request goes
`timescale 1ns/1ps
module crmi_arbiter (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Bus initialize
  input wire logic bus_request_line, // Request from block
  input wire logic vector_valid, // Vector strobe
  input wire logic [3:0] delay, // Grant delay in cycles
  output logic bus_grant // Grant to block
);
  logic [3:0] cnt;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 4'h0;
      bus_grant <= 1'b0;
    end else if (vector_valid || !bus_request_line) begin
      cnt <= 4'h0;
      bus_grant <= 1'b0;
    end else if (cnt == delay) begin
      bus_grant <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

//--- bench/tb_crmi_top.sv
// Purpose: self-checking bench for the maintenance and interrupt block
// Assumes: arbiter model grants requests
// Notes: driver queues expectations, watcher compares them
`timescale 1ns/1ps
`include "crmi_params.svh"
module tb_crmi_top;
  import crmi_pkg::*;
  logic clock = 0, sys_rst = 1, override_enable_wr = 0, irq_enable_bit = 0;
  logic bus_grant, override_enable_active, bus_request_line, vector_valid;
  logic [15:0] override_enable_wdata = 16'h0000;
  logic [15:0] d;
  crmi_reader_s reader_in = '0, status_out;
  crmi_src_s irq_src = '0;
  logic [2:0] bus_request_level;
  logic [8:0] vector_addr;
  logic [3:0] delay = 4'h0;
  logic [16:0] expq[$], vq[$];
  logic chk = 0;
  int miscompares = 0, compares = 0, cycles = 0, seed = 32'h4625_f448;
  crmi_top i_crmi_top (.clock, .sys_rst, .override_enable_wr, .override_enable_wdata,
    .reader_in, .irq_src, .irq_enable_bit, .bus_grant, .status_out,
    .override_enable_active, .bus_request_line, .bus_request_level, .vector_valid,
    .vector_addr);
  crmi_arbiter i_crmi_arbiter (.clock, .sys_rst, .bus_request_line,
    .vector_valid, .delay, .bus_grant);
  initial forever #2.5 clock = ~clock;
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [16:0] exp);
    expq.push_back(exp);
    chk <= 1'b1;
    @(posedge clock);
    chk <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] data, input logic [16:0] exp);
    override_enable_wr <= 1'b1;
    override_enable_wdata <= data;
    @(posedge clock);
    override_enable_wr <= 1'b0;
    repeat (3) @(posedge clock);
    check(exp);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
    if (chk) cmp({override_enable_active, status_out}, expq.pop_front());
    if (vector_valid) begin
      cmp({5'h0, bus_request_level, vector_addr}, vq.pop_front());
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed));
      reader_in <= 16'($random(seed));
      wr(d | 16'h8000, {1'b1, d[14:12], d[12:0]});
    end
    reader_in <= 16'($random(seed));
    repeat (6) @(posedge clock);
    wr(16'h7fff, {1'b0, reader_in});
    wr(16'hffff, 17'h1_ffff);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    check({1'b0, reader_in});
    irq_enable_bit <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      delay <= 4'(i * 2);
      vq.push_back({5'h0, `CRMI_DEF_LEVEL, `CRMI_DEF_VECTOR});
      irq_src <= 4'h1 << (i % 4);
      for (int k = 0; k < 40 && vq.size() > 0; k++) @(posedge clock);
      cmp(17'(vq.size()), 17'h0_0000);
      repeat (8) @(posedge clock);
      cmp({16'h0000, bus_request_line}, 17'h0_0000);
      irq_src <= '0;
      repeat (3) @(posedge clock);
    end
    irq_enable_bit <= 1'b0;
    irq_src <= 4'hf;
    repeat (10) @(posedge clock);
    cmp({16'h0000, bus_request_line}, 17'h0_0000);
    delay <= 4'hf;
    irq_enable_bit <= 1'b1;
    repeat (3) @(posedge clock);
    cmp({16'h0000, bus_request_line}, 17'h0_0001);
    irq_enable_bit <= 1'b0;
    repeat (3) @(posedge clock);
    cmp({16'h0000, bus_request_line}, 17'h0_0000);
    give_verdict();
  end
endmodule

//--- src/crmi_params.svh
// Purpose: constants for the card reader maintenance and interrupt block
// Assumes: included by bare name
// Notes: bit positions of the maintenance override register
`ifndef CRMI_PARAMS_SVH
`define CRMI_PARAMS_SVH
`define CRMI_OVERRIDE_ENABLE_RESET 16'h0000
`define CRMI_BIT_OVERRIDE 15
`define CRMI_BIT_BUSY 14
`define CRMI_BIT_READY 13
`define CRMI_BIT_MOTHOP 12
`define CRMI_ZONE_MSB 11
`define CRMI_DEF_LEVEL 3'h6
`define CRMI_DEF_VECTOR 9'h098
`endif

//--- src/crmi_pkg.sv
// Purpose: types for the card reader maintenance and interrupt block
// Assumes: none
// Notes: reader status travels as one packed struct
package crmi_pkg;
  typedef struct packed {
    logic busy;
    logic ready;
    logic feed_fault_a_fault;
    logic hopper_fault;
    logic [11:0] column;
  } crmi_reader_s;
  typedef struct packed {
    logic offline_error;
    logic card_done;
    logic went_online;
    logic column_ready;
  } crmi_src_s;
  typedef enum logic [1:0] {
    CRMI_IDLE,
    CRMI_REQUEST,
    CRMI_VECTOR,
    CRMI_WAIT_CLEAR
  } crmi_irq_e;
endpackage

//--- src/crmi_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: single clock domain for the output
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module crmi_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [WIDTH-1:0] din, // Asynchronous input
  output logic [WIDTH-1:0] dout // Filtered output
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } crmi_sync_s;

  crmi_sync_s st;
  crmi_sync_s next_st;
  logic [WIDTH-1:0] agreed;

  // Each bit moves only once the last two stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign agreed[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.held[i];
  end

  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.held = agreed;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.held;
endmodule

//--- src/crmi_top.sv
// Purpose: maintenance override muxes and vectored interrupt request
// Assumes: reader signals and bus grant are asynchronous pins
// Notes: register is write only; no read path exists
// Operation
// RULE1 - Bit 15 enables maintenance; writes keep it
// RULE2 - Override selects register over reader inputs
// RULE3 - Bit 14 drives internal busy
// RULE4 - Bit 13 drives internal ready
// RULE5 - Bit 12 drives feed_fault_a and hopper faults
// RULE6 - Low twelve bits simulate column data
// RULE7 - Column bits keep buffer bit positions
// RULE8 - Request bus, then supply vector when granted
// RULE9 - No request without interrupt enable
// RULE10 - Any of four sources raises request
// RULE11 - Default level 6, vector 230 octal
// RULE12 - Level and vector are strap parameters
// RULE13 - Register write only, cleared by initialize
// RULE14 - Withdraw when sources clear; rearm on new source
`timescale 1ns/1ps
`include "crmi_params.svh"
module crmi_top #(
  parameter logic [2:0] IRQ_LEVEL = `CRMI_DEF_LEVEL,
  parameter logic [8:0] IRQ_VECTOR = `CRMI_DEF_VECTOR
) (
  input wire logic clock, // 200 MHz system clock
  input wire logic sys_rst, // Bus initialize, async active high
  input wire logic override_enable_wr, // One-cycle write strobe
  input wire logic [15:0] override_enable_wdata, // Write data
  input wire crmi_pkg::crmi_reader_s reader_in, // Reader pins
  input wire crmi_pkg::crmi_src_s irq_src, // Status sources, local
  input wire logic irq_enable_bit, // Interrupt enable, local
  input wire logic bus_grant, // Grant pin from arbiter
  output crmi_pkg::crmi_reader_s status_out, // Muxed status and column
  output logic override_enable_active, // Override enable state
  output logic bus_request_line, // Bus request, active high
  output logic [2:0] bus_request_level, // Priority level of request
  output logic vector_valid, // Vector on bus, active high
  output logic [8:0] vector_addr // Interrupt vector address
);
  import crmi_pkg::*;

  typedef struct packed {
    logic [15:0] override_enable;
    crmi_irq_e irq;
    crmi_reader_s status;
    logic breq;
    logic vvalid;
    logic [2:0] level;
    logic [8:0] vector;
  } crmi_state_s;

  crmi_state_s st;
  crmi_state_s next_st;
  crmi_reader_s reader_sync;
  logic grant_sync;
  logic any_src;

  crmi_sync #(.WIDTH(17)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din({reader_in, bus_grant}),
    .dout({reader_sync, grant_sync})
  );

  assign any_src = |irq_src; // [RULE10]

  always_comb begin
    next_st = st;
    if (override_enable_wr) begin
      next_st.override_enable = override_enable_wdata; // [RULE1]
    end
    if (st.override_enable[`CRMI_BIT_OVERRIDE]) begin // [RULE2]
      next_st.status.busy = st.override_enable[`CRMI_BIT_BUSY]; // [RULE3]
      next_st.status.ready = st.override_enable[`CRMI_BIT_READY]; // [RULE4]
      next_st.status.feed_fault_a_fault = st.override_enable[`CRMI_BIT_MOTHOP]; // [RULE5]
      next_st.status.hopper_fault = st.override_enable[`CRMI_BIT_MOTHOP]; // [RULE5]
      next_st.status.column = st.override_enable[`CRMI_ZONE_MSB:0]; // [RULE6] [RULE7]
    end else begin
      next_st.status = reader_sync;
    end
    next_st.vvalid = 1'b0;
    // Strap values are held in flops so the outputs come from registers
    next_st.level = IRQ_LEVEL; // [RULE11] [RULE12]
    next_st.vector = IRQ_VECTOR; // [RULE11] [RULE12]
    case (st.irq)
      CRMI_IDLE: begin
        next_st.breq = 1'b0;
        if (irq_enable_bit && any_src) begin // [RULE9] [RULE10]
          next_st.irq = CRMI_REQUEST;
          next_st.breq = 1'b1; // [RULE8]
        end
      end
      CRMI_REQUEST: begin
        if (!irq_enable_bit || !any_src) begin // [RULE14]
          next_st.irq = CRMI_IDLE;
          next_st.breq = 1'b0;
        end else if (grant_sync) begin // [RULE8]
          next_st.irq = CRMI_VECTOR;
          next_st.breq = 1'b0;
          next_st.vvalid = 1'b1;
        end
      end
      CRMI_VECTOR: begin
        next_st.irq = CRMI_WAIT_CLEAR;
      end
      CRMI_WAIT_CLEAR: begin
        next_st.breq = 1'b0;
        if (!irq_enable_bit || !any_src) begin // [RULE14]
          next_st.irq = CRMI_IDLE;
        end
      end
      default: begin
        next_st.irq = CRMI_IDLE;
        next_st.breq = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{override_enable: `CRMI_OVERRIDE_ENABLE_RESET, irq: CRMI_IDLE, status: '0,
              breq: 1'b0, vvalid: 1'b0, level: IRQ_LEVEL,
              vector: IRQ_VECTOR}; // [RULE13]
    end else begin
      st <= next_st;
    end
  end

  assign status_out = st.status;
  assign override_enable_active = st.override_enable[`CRMI_BIT_OVERRIDE];
  assign bus_request_line = st.breq;
  assign bus_request_level = st.level; // [RULE11] [RULE12]
  assign vector_valid = st.vvalid;
  assign vector_addr = st.vector; // [RULE11] [RULE12]

  // Grant seen while a request still has a live cause
  sequence s_granted;
    st.irq == CRMI_REQUEST && grant_sync && irq_enable_bit && any_src;
  endsequence

  // Vector strobe for one cycle with the request already dropped
  sequence s_vector_pulse;
    vector_valid && !bus_request_line ##1 !vector_valid;
  endsequence

  a_mux_busy: assert property ( // [RULE3]
    @(posedge clock) disable iff (sys_rst)
    st.override_enable[`CRMI_BIT_OVERRIDE] |=>
      status_out.busy == $past(st.override_enable[`CRMI_BIT_BUSY]))
    else $error("busy not forced from register");
  a_mux_ready: assert property ( // [RULE4]
    @(posedge clock) disable iff (sys_rst)
    st.override_enable[`CRMI_BIT_OVERRIDE] |=>
      status_out.ready == $past(st.override_enable[`CRMI_BIT_READY]))
    else $error("ready not forced from register");
  a_mothop_joint: assert property ( // [RULE5]
    @(posedge clock) disable iff (sys_rst)
    st.override_enable[`CRMI_BIT_OVERRIDE] |=>
      status_out.feed_fault_a_fault == $past(st.override_enable[`CRMI_BIT_MOTHOP])
      && status_out.hopper_fault == $past(st.override_enable[`CRMI_BIT_MOTHOP]))
    else $error("feed_fault_a and hopper not jointly forced");
  a_zone_data: assert property ( // [RULE6]
    @(posedge clock) disable iff (sys_rst)
    st.override_enable[`CRMI_BIT_OVERRIDE] |=>
      status_out.column == $past(st.override_enable[`CRMI_ZONE_MSB:0]))
    else $error("column data not from register");
  a_reader_pass: assert property ( // [RULE2]
    @(posedge clock) disable iff (sys_rst)
    !st.override_enable[`CRMI_BIT_OVERRIDE] |=>
      status_out == $past(reader_sync))
    else $error("reader status not passed through");
  a_write_stores: assert property ( // [RULE1]
    @(posedge clock) disable iff (sys_rst)
    override_enable_wr |=> st.override_enable == $past(override_enable_wdata))
    else $error("maintenance write not stored");
  a_write_active: assert property ( // [RULE1]
    @(posedge clock) disable iff (sys_rst)
    override_enable_wr |=>
      override_enable_active == $past(override_enable_wdata[`CRMI_BIT_OVERRIDE]))
    else $error("override enable not taken from write");
  a_override_enable_hold: assert property ( // [RULE1]
    @(posedge clock) disable iff (sys_rst)
    !override_enable_wr |=> $stable(st.override_enable))
    else $error("maintenance register changed without write");
  a_no_enable: assert property ( // [RULE9]
    @(posedge clock) disable iff (sys_rst)
    !irq_enable_bit |=> !bus_request_line)
    else $error("request without interrupt enable");
  a_idle_quiet: assert property ( // [RULE9]
    @(posedge clock) disable iff (sys_rst)
    st.irq == CRMI_IDLE && !(irq_enable_bit && any_src) |=>
      !bus_request_line && !vector_valid)
    else $error("idle logic raised request or vector");
  a_raise_req: assert property ( // [RULE10]
    @(posedge clock) disable iff (sys_rst)
    st.irq == CRMI_IDLE && irq_enable_bit && any_src
      |=> bus_request_line)
    else $error("source did not raise request");
  a_req_cause: assert property ( // [RULE10]
    @(posedge clock) disable iff (sys_rst)
    $rose(bus_request_line) |->
      $past(irq_enable_bit) && $past(any_src))
    else $error("request rose without enabled source");
  a_req_holds: assert property ( // [RULE8]
    @(posedge clock) disable iff (sys_rst)
    bus_request_line && irq_enable_bit && any_src && !grant_sync
      |=> bus_request_line)
    else $error("request dropped before grant");
  a_grant_vector: assert property ( // [RULE8]
    @(posedge clock) disable iff (sys_rst)
    s_granted |=> s_vector_pulse)
    else $error("vector not supplied once after grant");
  a_vec_cause: assert property ( // [RULE8]
    @(posedge clock) disable iff (sys_rst)
    vector_valid |-> $past(grant_sync) && $past(bus_request_line))
    else $error("vector without granted request");
  a_withdraw: assert property ( // [RULE14]
    @(posedge clock) disable iff (sys_rst)
    bus_request_line && !any_src |=> !bus_request_line)
    else $error("request not withdrawn");
  a_no_rearm: assert property ( // [RULE14]
    @(posedge clock) disable iff (sys_rst)
    st.irq == CRMI_WAIT_CLEAR |=> !bus_request_line)
    else $error("request raised again before sources cleared");
  a_default_vec: assert property ( // [RULE11]
    @(posedge clock) disable iff (sys_rst)
    vector_valid |-> vector_addr == IRQ_VECTOR
      && bus_request_level == IRQ_LEVEL)
    else $error("wrong vector or level");
  a_level_steady: assert property ( // [RULE12]
    @(posedge clock) disable iff (sys_rst)
    bus_request_line |-> bus_request_level == IRQ_LEVEL)
    else $error("request level differs from strap");
endmodule
